// file: bcbu_pkg.sv
// Constants and carrier types shared by the bus cycle breakpoint unit.
// Assumes a single pclk domain; bus cycle observations arrive on that clock.
package bcbu_pkg;

  // ==========================================================================
  // Register indices (byte address on APB is four times the index)
  // ==========================================================================
  localparam int NUM_CFG = 5;
  localparam logic [27:0] IDX_ADDR_HIGH = 28'h5FFFF90;
  localparam logic [27:0] IDX_ADDR_LOW = 28'h5FFFF92;
  localparam logic [27:0] IDX_MASK_HIGH = 28'h5FFFF94;
  localparam logic [27:0] IDX_MASK_LOW = 28'h5FFFF96;
  localparam logic [27:0] IDX_CYCLE_SEL = 28'h5FFFF98;
  localparam logic [27:0] IDX_IRQ_STATUS = 28'h5FFFF9A;
  localparam logic [27:0] IDX_IRQ_MASK = 28'h5FFFF9C;
  localparam logic [27:0] CFG_IDX [NUM_CFG] = '{IDX_ADDR_HIGH, IDX_ADDR_LOW, IDX_MASK_HIGH,
                                                IDX_MASK_LOW, IDX_CYCLE_SEL};
  // Only index bits 27..24 and 8..0 take part in the decode
  localparam logic [27:0] IDX_DEC_MASK = 28'hF0001FF;

  // Slots of the configuration array
  localparam int CFG_ADDR_HIGH = 0;
  localparam int CFG_ADDR_LOW = 1;
  localparam int CFG_MASK_HIGH = 2;
  localparam int CFG_MASK_LOW = 3;
  localparam int CFG_CYCLE_SEL = 4;

  // ==========================================================================
  // Reset values and writable bits
  // ==========================================================================
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK [NUM_CFG] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF};
  localparam int IRQ_BITS = 2;
  localparam logic [IRQ_BITS-1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 2'h1;
  localparam int STAT_BREAK = 0;
  localparam int STAT_MISSED = 1;

  // ==========================================================================
  // Cycle select field layout and encodings
  // ==========================================================================
  localparam int OWNER_LSB = 6;
  localparam int TYPE_LSB = 4;
  localparam int DIR_LSB = 2;
  localparam int SIZE_LSB = 0;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SIZE_ANY = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // One observed bus cycle
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic is_dma;
    logic is_fetch;
    logic is_write;
    logic [1:0] size;
  } bcbu_cycle_s;

endpackage

// file: bcbu_top.sv
// Bus cycle breakpoint unit: compares each observed bus cycle against the
// programmed break conditions and raises a user break request.
// Assumes an APB master on pclk and bus cycle reports on the same clock.
//
// How it works
// - Software selects breaks by address, CPU or DMA owner, fetch or data, read or write, and operand size.
// - A bus cycle matching every enabled condition raises the user break request to the interrupt controller.
// - A matched instruction fetch is flagged at once so the core breaks before that instruction executes.
// - Five configuration registers sit at every second index, 2 apart, from address high to cycle select.
// - Register decode looks at index bits 27 to 24 and 8 to 0 only, ignoring bits 23 to 9.
// - The high address register holds break address bits 31 to 16 and the low one bits 15 to 0.
// - Both address registers are 16 bits wide and fully readable and writable.
// - Reset clears the address registers to zero while standby leaves them untouched.
// - A mask bit of one drops that address bit from the compare, a zero requires it to match.
// - Owner, type and direction fields mean 00 none, 01 first kind, 10 second kind, 11 both.
// - Any of owner, type or direction field at 00 blocks every break.
// - Size field means 00 any, 01 byte, 10 word, 11 longword, and fetches count as word accesses.
module bcbu_top
  import bcbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire bcbu_cycle_s bus_cycle,
  input wire logic standby,
  input wire logic break_ack,
  output logic fetch_break,
  output logic break_irq
);

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic [27:0] idx;
  logic setup_phase;
  logic access_wr;
  logic [NUM_CFG-1:0] cfg_sel;
  logic stat_sel;
  logic imask_sel;
  logic mapped;

  function automatic logic idx_match(input logic [27:0] a, input logic [27:0] b);
    return ((a ^ b) & IDX_DEC_MASK) == 28'h0000000;
  endfunction

  // Keep reserved bits at zero and honour byte lanes of the low halfword
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] nxt;
    nxt = old;
    if (strb[0]) begin
      nxt[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      nxt[15:8] = wd[15:8];
    end
    return nxt & wmask;
  endfunction

  assign idx = paddr[29:2];
  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite && pready;
  assign stat_sel = idx_match(idx, IDX_IRQ_STATUS);
  assign imask_sel = idx_match(idx, IDX_IRQ_MASK);
  assign mapped = (|cfg_sel) || stat_sel || imask_sel;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [15:0] cfg_q [NUM_CFG];

  // Not reset by standby: only presetn resets these
  generate
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      assign cfg_sel[i] = idx_match(idx, CFG_IDX[i]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_q[i] <= CFG_RESET;
        end else if (access_wr && cfg_sel[i]) begin
          cfg_q[i] <= lane_merge(cfg_q[i], pwdata, pstrb, CFG_WMASK[i]);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Break match
  // ==========================================================================
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [7:0] sel;
  logic addr_ok;
  logic owner_ok;
  logic type_ok;
  logic dir_ok;
  logic size_ok;
  logic [1:0] eff_size;
  logic hit;

  assign brk_addr = {cfg_q[CFG_ADDR_HIGH], cfg_q[CFG_ADDR_LOW]};
  assign brk_mask = {cfg_q[CFG_MASK_HIGH], cfg_q[CFG_MASK_LOW]};
  assign sel = cfg_q[CFG_CYCLE_SEL][7:0];
  assign addr_ok = ((bus_cycle.addr ^ brk_addr) & ~brk_mask) == 32'h00000000;
  // Low bit of each pair selects the first kind, high bit the second
  assign owner_ok = bus_cycle.is_dma ? sel[OWNER_LSB+1] : sel[OWNER_LSB];
  assign type_ok = bus_cycle.is_fetch ? sel[TYPE_LSB] : sel[TYPE_LSB+1];
  assign dir_ok = bus_cycle.is_write ? sel[DIR_LSB+1] : sel[DIR_LSB];
  // Fetches are word accesses whatever the bus width of the space
  assign eff_size = bus_cycle.is_fetch ? SIZE_WORD : bus_cycle.size;
  assign size_ok = (sel[SIZE_LSB+:2] == SIZE_ANY) || (sel[SIZE_LSB+:2] == eff_size);
  // No breaks while in standby, the bus is quiet then anyway
  assign hit = bus_cycle.valid && !standby && addr_ok && owner_ok && type_ok && dir_ok && size_ok;
  // Combinational so the core can tag the instruction in the fetch cycle
  assign fetch_break = hit && bus_cycle.is_fetch;

  // ==========================================================================
  // Interrupt status and mask
  // ==========================================================================
  logic [IRQ_BITS-1:0] stat_q;
  logic [IRQ_BITS-1:0] imask_q;
  logic [IRQ_BITS-1:0] stat_set;
  logic [IRQ_BITS-1:0] stat_clr;

  assign stat_set[STAT_BREAK] = hit;
  // A further match while a break is still pending is recorded as missed
  assign stat_set[STAT_MISSED] = hit && stat_q[STAT_BREAK];
  assign stat_clr[STAT_BREAK] = (access_wr && stat_sel && pstrb[0] && pwdata[STAT_BREAK]) || break_ack;
  assign stat_clr[STAT_MISSED] = access_wr && stat_sel && pstrb[0] && pwdata[STAT_MISSED];

  // Set wins over clear so no match is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= IRQ_STATUS_RESET;
    end else begin
      stat_q <= stat_set | (stat_q & ~stat_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= IRQ_MASK_RESET;
    end else if (access_wr && imask_sel && pstrb[0]) begin
      imask_q <= pwdata[IRQ_BITS-1:0];
    end
  end

  assign break_irq = |(stat_q & imask_q);

  // ==========================================================================
  // Read data, captured in the setup cycle
  // ==========================================================================
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h00000000;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (cfg_sel[i]) begin
        rd_d = {16'h0000, cfg_q[i]};
      end
    end
    if (stat_sel) begin
      rd_d = {{(32 - IRQ_BITS){1'b0}}, stat_q};
    end
    if (imask_sel) begin
      rd_d = {{(32 - IRQ_BITS){1'b0}}, imask_q};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_d;
      pslverr_q <= !mapped;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_hit_sets_break: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> stat_q[STAT_BREAK])
    else $error("match did not set break status");

  a_irq_after_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (hit && imask_q[STAT_BREAK] && !(access_wr && imask_sel)) |=> break_irq)
    else $error("unmasked match did not raise break request");

  a_request_held: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_q[STAT_BREAK] && imask_q[STAT_BREAK] && !break_ack && !access_wr) |=> break_irq)
    else $error("break request dropped before acceptance");

  a_fetch_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_cycle.valid && bus_cycle.is_fetch && hit) |-> fetch_break ##1 stat_q[STAT_BREAK])
    else $error("matched fetch not flagged in its own cycle");

  a_owner_none: assert property (@(posedge pclk) disable iff (!presetn)
    (sel[OWNER_LSB+:2] == SEL_NONE || sel[TYPE_LSB+:2] == SEL_NONE || sel[DIR_LSB+:2] == SEL_NONE) |-> !hit)
    else $error("break raised with a select field at none");

  a_dir_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    (sel[DIR_LSB+:2] == 2'h1 && bus_cycle.is_write) |-> !fetch_break && !hit)
    else $error("write cycle matched a read-only selection");

  a_full_mask_hits: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_cycle.valid && !standby && brk_mask == 32'hFFFFFFFF && sel == 8'hFC) |-> hit)
    else $error("fully masked address with all kinds selected did not match");

  a_fetch_as_word: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_cycle.is_fetch && sel[SIZE_LSB+:2] == SIZE_BYTE) |-> !hit)
    else $error("fetch matched a byte size selection");

  a_addr_high_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && cfg_sel[CFG_ADDR_HIGH] && pstrb[1:0] == 2'h3) |=>
      brk_addr[31:16] == $past(pwdata[15:0]))
    else $error("address high register did not take written value");

  a_alias_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && ((idx ^ IDX_ADDR_LOW) & ~28'h0FFFE00) == 28'h0000000) |=>
      !pslverr && (pwrite || prdata == {16'h0000, brk_addr[15:0]}))
    else $error("aliased address low read failed");

  // ==========================================================================
  // Checks on register access and break qualification
  // ==========================================================================
  // Unmapped indices answer with an error and read as zero
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !mapped) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access did not report an error");

  a_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && mapped) |=> !pslverr)
    else $error("mapped access reported an error");

  a_addr_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && cfg_sel[CFG_ADDR_LOW] && pstrb[1:0] == 2'h3) |=>
      brk_addr[15:0] == $past(pwdata[15:0]))
    else $error("address low register did not take written value");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && cfg_sel[CFG_MASK_LOW] && pstrb[1:0] == 2'h3) |=>
      brk_mask[15:0] == $past(pwdata[15:0]))
    else $error("mask low register did not take written value");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && cfg_sel[CFG_CYCLE_SEL]) |=> cfg_q[CFG_CYCLE_SEL][15:8] == 8'h00)
    else $error("reserved cycle select bits took a write");

  // Standby only stops matching; the conditions themselves stay put
  a_standby_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (standby && !access_wr) |=> brk_addr == $past(brk_addr) && brk_mask == $past(brk_mask))
    else $error("break conditions changed in standby");

  // An unmasked address difference must always block the break
  a_addr_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (((bus_cycle.addr ^ brk_addr) & ~brk_mask) != 32'h00000000) |-> !hit)
    else $error("unmasked address difference still matched");

  a_size_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (!bus_cycle.is_fetch && sel[SIZE_LSB+:2] != SIZE_ANY && sel[SIZE_LSB+:2] != bus_cycle.size) |->
      !hit)
    else $error("data cycle of another size matched");

  a_owner_both: assert property (@(posedge pclk) disable iff (!presetn)
    (bus_cycle.valid && !standby && addr_ok && sel == 8'hFC) |-> hit)
    else $error("cycle missed with both kinds selected everywhere");

  a_data_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_cycle.is_fetch |-> !fetch_break)
    else $error("data cycle flagged as fetch break");

  // A pending break must not swallow a second match silently
  a_missed_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (hit && stat_q[STAT_BREAK]) |=> stat_q[STAT_MISSED])
    else $error("second match while pending not recorded");

  a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (break_ack && !hit) |=> !stat_q[STAT_BREAK])
    else $error("accepted break still pending");

  a_write_one_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && stat_sel && pstrb[0] && pwdata[STAT_BREAK] && !hit) |=> !stat_q[STAT_BREAK])
    else $error("write of one did not clear break status");

endmodule

// file: bcbu_bus_model.sv
// Far-side model: core and DMA bus cycles plus the interrupt controller.
// Assumes the bench calls drive and idle right after a rising pclk edge.
module bcbu_bus_model
  import bcbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic break_irq,
  input wire logic [3:0] ack_delay,
  output bcbu_cycle_s bus_cycle,
  output logic break_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  initial bus_cycle = '0;
  // ====
  // Bus cycles
  task automatic drive(input bcbu_cycle_s c);
    bus_cycle <= c;
  endtask
  // Idle bus never shows the last address, so stale matches cannot hide
  task automatic idle();
    bus_cycle.valid <= 1'b0;
    bus_cycle.addr <= ~bus_cycle.addr;
  endtask
  // ====
  // Interrupt acceptance; zero delay means software must clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      break_ack <= 1'b0;
    end else if (break_irq && !break_ack && ack_delay != 4'h0) begin
      wait_q <= wait_q + 4'h1;
      break_ack <= (wait_q + 4'h1 >= ack_delay);
    end else begin
      wait_q <= 4'h0;
      break_ack <= 1'b0;
    end
  end
endmodule

// file: testbench.sv
// Self-checking bench for the bus cycle breakpoint unit.
// Assumes bcbu_pkg, bcbu_top and bcbu_bus_model are compiled first.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
  import bcbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF, ack_delay = 4'h0;
  logic pready, pslverr, fetch_break, break_irq, break_ack, er;
  bcbu_cycle_s bus_cycle;
  int err_total = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  bcbu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bus_cycle(bus_cycle), .standby(standby), .break_ack(break_ack),
    .fetch_break(fetch_break), .break_irq(break_irq));
  bcbu_bus_model bfm (.pclk(pclk), .presetn(presetn), .break_irq(break_irq),
    .ack_delay(ack_delay), .bus_cycle(bus_cycle), .break_ack(break_ack));
  // ====
  // Access tasks
  task automatic apb(input logic wr, input logic [27:0] idx, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [27:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 16'h0000);
    `CHK("read data", e, rd)
  endtask
  function automatic bcbu_cycle_s cyc(input logic [31:0] a, input logic [2:0] k, input logic [1:0] sz);
    return '{1'b1, a, k[2], k[1], k[0], sz};
  endfunction
  // One cycle on the bus, then status cleared by write-one
  task automatic probe(input bcbu_cycle_s c, input logic e);
    bfm.drive(c);
    #1;
    `CHK("fetch break", e & c.is_fetch, fetch_break)
    @(posedge pclk);
    bfm.idle();
    #1;
    `CHK("break request", e, break_irq)
    apb(1'b1, IDX_IRQ_STATUS, 16'h0003);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    final_report();
  end
  // ====
  // Tests
  initial begin
    logic [7:0] cs;
    logic [1:0] sel;
    logic e;
    do_reset();
    for (int i = 0; i < NUM_CFG; i++) begin
      rchk(CFG_IDX[i], 32'h0);
      apb(1'b1, CFG_IDX[i], 16'hFFFF);
      rchk(CFG_IDX[i], {16'h0000, CFG_WMASK[i]});
    end
    rchk(IDX_IRQ_STATUS, 32'h0);
    rchk(IDX_IRQ_MASK, {30'h0, IRQ_MASK_RESET});
    do_reset();
    rchk(IDX_ADDR_HIGH, 32'h0);
    $display("test registers done");
    apb(1'b1, IDX_ADDR_HIGH ^ 28'h0FFFE00, 16'h1234);
    apb(1'b1, IDX_ADDR_LOW, 16'h5678);
    apb(1'b1, IDX_MASK_LOW, 16'h00F0);
    rchk(IDX_ADDR_HIGH, 32'h1234);
    rchk(28'h5FFFF9E, 32'h0);
    `CHK("slave error", 1'b1, er)
    `CHK("ready", 1'b1, pready)
    apb(1'b1, IDX_CYCLE_SEL, 16'h00FC);
    probe(cyc(32'h123456A8, 3'b000, 2'h2), 1'b1);
    probe(cyc(32'h12345679, 3'b000, 2'h2), 1'b0);
    probe(cyc(32'h92345678, 3'b110, 2'h2), 1'b0);
    probe(cyc(32'h12345678, 3'b010, 2'h2), 1'b1);
    $display("test address done");
    for (int f = 0; f < 3; f++)
      for (int s = 0; s < 4; s++)
        for (int k = 0; k < 2; k++) begin
          sel = 2'(s);
          cs = (8'hFC & ~(8'h03 << (6 - 2 * f))) | ({6'h00, sel} << (6 - 2 * f));
          apb(1'b1, IDX_CYCLE_SEL, {8'h00, cs});
          probe(cyc(32'h12345678, f == 0 ? {k[0], 2'b00} : f == 1 ? {1'b0, ~k[0], 1'b0}
            : {2'b00, k[0]}, 2'h2), sel[k]);
        end
    for (int s = 0; s < 4; s++)
      for (int t = 1; t < 7; t++) begin
        sel = 2'((t - 1) % 3 + 1);
        e = (s == 0) || (s == (t > 3 ? 2 : int'(sel)));
        apb(1'b1, IDX_CYCLE_SEL, 16'h00FC | 16'(s));
        probe(cyc(32'h12345678, t > 3 ? 3'b010 : 3'b001, sel), e);
      end
    $display("test conditions done");
    apb(1'b1, IDX_CYCLE_SEL, 16'h00FC);
    bfm.drive(cyc(32'h12345678, 3'b100, 2'h3));
    repeat (2) @(posedge pclk);
    bfm.idle();
    repeat (4) @(posedge pclk);
    #1 `CHK("held request", 1'b1, break_irq)
    rchk(IDX_IRQ_STATUS, 32'h3);
    ack_delay <= 4'h3;
    repeat (8) @(posedge pclk);
    ack_delay <= 4'h0;
    #1 `CHK("accepted request", 1'b0, break_irq)
    rchk(IDX_IRQ_STATUS, 32'h2);
    apb(1'b1, IDX_IRQ_STATUS, 16'h0002);
    apb(1'b1, IDX_IRQ_MASK, 16'h0000);
    bfm.drive(cyc(32'h12345678, 3'b000, 2'h1));
    @(posedge pclk);
    bfm.idle();
    rchk(IDX_IRQ_STATUS, 32'h1);
    #1 `CHK("masked request", 1'b0, break_irq)
    apb(1'b1, IDX_IRQ_MASK, 16'h0001);
    #1 `CHK("unmasked request", 1'b1, break_irq)
    apb(1'b1, IDX_IRQ_STATUS, 16'h0001);
    #1 `CHK("cleared request", 1'b0, break_irq)
    $display("test interrupt done");
    // Every address bit masked: any cycle with all kinds selected breaks
    apb(1'b1, IDX_MASK_HIGH, 16'hFFFF);
    apb(1'b1, IDX_MASK_LOW, 16'hFFFF);
    probe(cyc(32'hA5A5A5A5, 3'b101, 2'h1), 1'b1);
    standby <= 1'b1;
    probe(cyc(32'h12345678, 3'b000, 2'h2), 1'b0);
    rchk(IDX_ADDR_LOW, 32'h5678);
    standby <= 1'b0;
    $display("test standby done");
    final_report();
  end
endmodule
